/* File: bench/general_purpose_port_io_tb.sv */
// Self-checking bench for the general-purpose port block
`timescale 1ns/1ps
module general_purpose_port_io_tb;
    logic        core_clk = 1'b0, rst = 1'b1;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rd_val;
    logic        sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0, sfr_bit_en = 1'b0;
    logic [2:0]  sfr_bit_sel = 3'h0;
    logic [39:0] pin_in, pin_out, pin_oe, pin_pullup_en, pin_analog;
    logic [39:0] periph_owned = 40'h0, periph_out = 40'h0, periph_oe = 40'h0;
    logic [39:0] ext_val = 40'h0, ext_en = 40'h0;
    logic        crossbar_enable = 1'b1, pullup_disable = 1'b0;
    logic        port_match, match_irq, match_wake;
    int          error_cnt = 0, samples_checked = 0;

    general_purpose_port_io u_dut (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw),
        .sfr_bit_en(sfr_bit_en), .sfr_bit_sel(sfr_bit_sel), .sfr_rdata(sfr_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
        .pin_analog(pin_analog), .periph_owned(periph_owned), .periph_out(periph_out),
        .periph_oe(periph_oe), .crossbar_enable(crossbar_enable),
        .pullup_disable(pullup_disable), .port_match(port_match), .match_irq(match_irq),
        .match_wake(match_wake));
    port_pins_model u_pins (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup_en(pin_pullup_en), .ext_val(ext_val), .ext_en(ext_en),
        .pin_level(pin_in));

    initial forever #20 core_clk = ~core_clk;

    task automatic end_sim();
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0,
                      input logic [2:0] s = 3'h0);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_bit_en = b;
        sfr_bit_sel = s;
        sfr_wr = 1'b1;
        @(negedge core_clk);
        sfr_wr = 1'b0;
        sfr_bit_en = 1'b0;
        @(negedge core_clk);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic m, input logic [7:0] exp);
        sfr_addr = a;
        sfr_rmw = m;
        sfr_rd = 1'b1;
        @(negedge core_clk);
        sfr_rd = 1'b0;
        sfr_rmw = 1'b0;
        chk(sfr_rdata, exp);
        @(negedge core_clk);
    endtask : rchk

    // Two synchroniser edges plus margin
    task automatic settle();
        repeat (3) @(negedge core_clk);
    endtask : settle

    task automatic t_reset();
        chk(pin_oe, 40'h0);
        chk(pin_analog, 40'h0);
        rchk(gpio_pkg::port0_input_mode_addr, 1'b0, 8'hff);
        rchk(gpio_pkg::port0_output_mode_addr, 1'b0, 8'h00);
        rchk(gpio_pkg::port0_data_addr, 1'b1, 8'hff);
        rchk(gpio_pkg::port4_data_addr, 1'b1, 8'h7f);
    endtask : t_reset

    task automatic t_drive();
        wr(gpio_pkg::port0_output_mode_addr, 8'hff);
        wr(gpio_pkg::port0_data_addr, 8'h5a);
        chk(pin_out[7:0], 8'h5a);
        chk(pin_oe[7:0], 8'hff);
        wr(gpio_pkg::port0_output_mode_addr, 8'h00);
        chk(pin_oe[7:0], 8'ha5);
        settle();
        rchk(gpio_pkg::port0_data_addr, 1'b0, 8'h5a);
        crossbar_enable = 1'b0;
        pullup_disable = 1'b1;
        @(negedge core_clk);
        chk(pin_oe[7:0], 8'h00);
        chk(pin_pullup_en, 40'h0);
        crossbar_enable = 1'b1;
        pullup_disable = 1'b0;
    endtask : t_drive

    task automatic t_rmw();
        wr(gpio_pkg::port0_data_addr, 8'hff);
        ext_en[7:0] = 8'hff;
        ext_val[7:0] = 8'h00;
        settle();
        rchk(gpio_pkg::port0_data_addr, 1'b0, 8'h00);
        rchk(gpio_pkg::port0_data_addr, 1'b1, 8'hff);
        wr(gpio_pkg::port0_data_addr, 8'h00, 1'b1, 3'h3);
        rchk(gpio_pkg::port0_data_addr, 1'b1, 8'hf7);
        wr(gpio_pkg::port4_data_addr, 8'h00, 1'b1, 3'h0);
        rchk(gpio_pkg::port4_data_addr, 1'b1, 8'h7f);
        wr(gpio_pkg::port4_data_addr, 8'hff);
        rchk(gpio_pkg::port4_data_addr, 1'b1, 8'h7f);
        ext_en[7:0] = 8'h00;
        wr(gpio_pkg::port0_data_addr, 8'hff);
    endtask : t_rmw

    task automatic t_periph();
        periph_owned[15:8] = 8'hff;
        ext_en[15:8] = 8'hff;
        ext_val[15:8] = 8'h3c;
        settle();
        rchk(gpio_pkg::port1_data_addr, 1'b0, 8'h3c);
        ext_en[15:8] = 8'h00;
        periph_oe[15:8] = 8'hff;
        periph_out[15:8] = 8'hc3;
        settle();
        rchk(gpio_pkg::port1_data_addr, 1'b0, 8'hc3);
        periph_owned = 40'h0;
        periph_oe = 40'h0;
    endtask : t_periph

    task automatic t_analog();
        wr(gpio_pkg::port2_output_mode_addr, 8'hff);
        wr(gpio_pkg::port2_input_mode_addr, 8'hfe);
        chk(pin_analog[23:16], 8'h01);
        chk(pin_oe[23:16], 8'hfe);
        chk(pin_pullup_en[16], 1'b0);
        ext_en[16] = 1'b1;
        ext_val[16] = 1'b1;
        settle();
        rchk(gpio_pkg::port2_data_addr, 1'b0, 8'hfe);
        wr(gpio_pkg::port2_input_mode_addr, 8'hff);
        wr(gpio_pkg::port2_output_mode_addr, 8'h00);
        ext_en = 40'h0;
    endtask : t_analog

    task automatic t_match(input int p);
        logic [7:0] va;
        va = gpio_pkg::port0_compare_value_addr + 8'(2 * p);
        ext_en[8*p +: 8] = 8'hff;
        ext_val[8*p +: 8] = 8'h96;
        wr(va, 8'h96);
        wr(va + 8'h01, 8'hf0);
        settle();
        chk(port_match, 1'b0);
        ext_val[8*p] = 1'b1;
        settle();
        chk(port_match, 1'b0);
        ext_val[8*p+7] = 1'b0;
        settle();
        chk({port_match, match_wake, match_irq}, 3'b110);
        wr(gpio_pkg::int_enable_two_addr, 8'h01 << gpio_pkg::pattern_int_enable_bit);
        chk(match_irq, 1'b1);
        periph_owned[8*p +: 8] = 8'hff;
        settle();
        chk(port_match, 1'b1);
        wr(gpio_pkg::int_enable_two_addr, 8'h00);
        wr(va + 8'h01, 8'h00);
        chk(port_match, 1'b0);
        periph_owned = 40'h0;
        ext_en = 40'h0;
    endtask : t_match

    initial
    begin
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        t_reset();
        t_drive();
        t_rmw();
        t_periph();
        t_analog();
        for (int p = 0; p < 3; p++)
            t_match(p);
        end_sim();
    end

    initial
    begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        end_sim();
    end
endmodule : general_purpose_port_io_tb

bind general_purpose_port_io gpio_port_checker u_chk (.core_clk(core_clk), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rmw(sfr_rmw), .sfr_bit_en(sfr_bit_en), .sfr_rdata(sfr_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .pin_analog(pin_analog), .periph_owned(periph_owned),
    .crossbar_enable(crossbar_enable), .pullup_disable(pullup_disable),
    .port_match(port_match), .match_irq(match_irq), .match_wake(match_wake));

/* File: bench/gpio_port_properties.sv */
// Checker of port block behaviour seen at its ports
`timescale 1ns/1ps
module gpio_port_checker (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [7:0]  sfr_addr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic        sfr_rmw,
    input wire logic        sfr_bit_en,
    input wire logic [7:0]  sfr_rdata,
    input wire logic [39:0] pin_in,
    input wire logic [39:0] pin_out,
    input wire logic [39:0] pin_oe,
    input wire logic [39:0] pin_pullup_en,
    input wire logic [39:0] pin_analog,
    input wire logic [39:0] periph_owned,
    input wire logic        crossbar_enable,
    input wire logic        pullup_disable,
    input wire logic        port_match,
    input wire logic        match_irq,
    input wire logic        match_wake
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    irq_gate_a: assert property (match_irq |-> port_match)
        else $error("irq without match");
    wake_follow_a: assert property (match_wake == port_match)
        else $error("wake differs from match");
    analog_drive_a: assert property ((pin_analog & pin_oe) == 40'h0)
        else $error("analog pin driven");
    analog_pullup_a: assert property ((pin_analog & pin_pullup_en) == 40'h0)
        else $error("analog pin pulled up");
    pullup_off_a: assert property (pullup_disable |-> pin_pullup_en == 40'h0)
        else $error("pull-up while disabled");
    xbar_off_a: assert property (!crossbar_enable |-> pin_oe == 40'h0)
        else $error("driver on while crossbar off");
    latch_write_a: assert property (sfr_wr && !sfr_bit_en
        && sfr_addr == gpio_pkg::port0_data_addr |=> periph_owned[7:0] != 8'h00
        || pin_analog[7:0] != 8'h00 || pin_out[7:0] == $past(sfr_wdata))
        else $error("latch not updated");
    rmw_read_a: assert property (sfr_rd && sfr_rmw && !sfr_wr
        && sfr_addr == gpio_pkg::port0_data_addr && periph_owned[7:0] == 8'h00
        && pin_analog[7:0] == 8'h00 |=> sfr_rdata == pin_out[7:0])
        else $error("rmw read not latch");
    pin_read_a: assert property (sfr_rd && !sfr_rmw && !$past(rst, 3)
        && sfr_addr == gpio_pkg::port1_data_addr && $stable(pin_in[15:8])
        && $past(pin_in[15:8], 2) == pin_in[15:8]
        |=> sfr_rdata == ($past(pin_in[15:8]) & ~$past(pin_analog[15:8])))
        else $error("pin read wrong");
    port4_msb_a: assert property (sfr_rd && sfr_addr == gpio_pkg::port4_data_addr
        |=> sfr_rdata[7] == 1'b0)
        else $error("port4 top bit set");
    rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data changed");
endmodule : gpio_port_checker

/* File: bench/port_pins_model.sv */
// Model of the circuitry wired to the port pins
`timescale 1ns/1ps
module port_pins_model (
    input wire logic        core_clk,
    input wire logic [39:0] pin_out,
    input wire logic [39:0] pin_oe,
    input wire logic [39:0] pin_pullup_en,
    input wire logic [39:0] ext_val,
    input wire logic [39:0] ext_en,
    output logic     [39:0] pin_level
);
    logic [39:0] float_r = 40'h0;
    // Undriven pins with no pull-up wander, so no test may lean on them
    always @(posedge core_clk) float_r <= ~float_r;
    always_comb
        for (int i = 0; i < 40; i++)
            pin_level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                           pin_pullup_en[i] ? 1'b1 : float_r[i];
endmodule : port_pins_model

/* File: design/general_purpose_port_io.sv */
// General-purpose port block: latches, pin reads, drivers and pattern compare
// Summary of operation
// - Pins not taken by peripherals or analog work as software-controlled I/O.
// - Ports 0-3 data allow byte and bit access; port 4 byte only.
// - Writes to a data register set the output latch, held until rewritten.
// - Ordinary data reads return pin levels, even for peripheral-owned pins.
// - Read-modify-write accesses read the latch instead of the pins.
// - Ports 0-2 flag a match when masked pins differ from masked value.
// - Match uses pin levels regardless of crossbar assignment.
// - A match requests interrupt only when the pattern enable bit is one.
// - A match wakes the oscillator from suspend, regardless of enable.
// - Input-mode bit zero makes the pin analog; one keeps it digital.
// - Analog pins lose pull-up, digital driver and digital receiver.
`timescale 1ns/1ps
module general_purpose_port_io #(
    parameter int PORTS = 5
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic        sfr_rmw,
    input  wire logic        sfr_bit_en,
    input  wire logic [2:0]  sfr_bit_sel,
    output logic      [7:0]  sfr_rdata,
    input  wire logic [39:0] pin_in,
    output logic      [39:0] pin_out,
    output logic      [39:0] pin_oe,
    output logic      [39:0] pin_pullup_en,
    output logic      [39:0] pin_analog,
    input  wire logic [39:0] periph_owned,
    input  wire logic [39:0] periph_out,
    input  wire logic [39:0] periph_oe,
    input  wire logic        crossbar_enable,
    input  wire logic        pullup_disable,
    output logic             port_match,
    output logic             match_irq,
    output logic             match_wake
);
    logic [7:0] data_r     [PORTS];
    logic [7:0] data_nxt   [PORTS];
    logic [7:0] inmode_r   [PORTS];
    logic [7:0] inmode_nxt [PORTS];
    logic [7:0] outmode_r  [PORTS];
    logic [7:0] outmode_nxt[PORTS];
    logic [7:0] cmp_val_r  [3];
    logic [7:0] cmp_val_nxt[3];
    logic [7:0] cmp_msk_r  [3];
    logic [7:0] cmp_msk_nxt[3];
    logic [7:0] int_en_r;
    logic [7:0] int_en_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [39:0] pin_sync_w;
    logic [7:0]  pin_lvl [PORTS];
    logic [2:0]  port_hit;

    pin_sync #(
        .WIDTH (40)
    ) u_pin_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (pin_in),
        .sync_out (pin_sync_w)
    );

    function automatic logic [7:0] bit_merge(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic       bit_en,
        input logic [2:0] bit_sel
    );
        logic [7:0] res;
        res = old_val;
        if (bit_en)
            res[bit_sel] = new_val[0];
        else
            res = new_val;
        return res;
    endfunction : bit_merge

    // Analog pins read as zero; digital receiver off
    genvar g;
    generate
        for (g = 0; g < PORTS; g++)
        begin : g_port
            always_comb
            begin
                pin_lvl[g] = pin_sync_w[g*8 +: 8] & inmode_r[g];
            end
            for (genvar b = 0; b < 8; b++)
            begin : g_pin
                localparam int N = g*8 + b;
                // Port 4 has no pin behind its top bit, so that bit never drives
                localparam bit pin_present = (g < 4) || gpio_pkg::port4_pin_mask[b];
                logic digital;
                logic drive_val;
                logic drive_en;
                always_comb
                begin
                    digital   = inmode_r[g][b];
                    drive_val = periph_owned[N] ? periph_out[N] : data_r[g][b];
                    if (!pin_present)
                        drive_en = 1'b0;
                    else if (periph_owned[N])
                        drive_en = periph_oe[N];
                    else if (outmode_r[g][b])
                        drive_en = 1'b1;
                    else
                        drive_en = ~data_r[g][b];
                end
                // Drivers stay off with the crossbar disabled or pin analog
                assign pin_out[N]       = drive_val & digital;
                assign pin_oe[N]        = drive_en & digital & crossbar_enable;
                assign pin_pullup_en[N] = digital & ~pullup_disable & ~pin_oe[N];
                assign pin_analog[N]    = ~digital;
            end
        end
    endgenerate

    // Compare ignores crossbar assignment: uses pins directly
    always_comb
    begin
        for (int p = 0; p < 3; p++)
            port_hit[p] = (pin_lvl[p] & cmp_msk_r[p]) != (cmp_val_r[p] & cmp_msk_r[p]);
    end

    assign port_match = |port_hit;
    assign match_irq  = port_match & int_en_r[gpio_pkg::pattern_int_enable_bit];
    assign match_wake = port_match;
    assign sfr_rdata  = rdata_r;

    always_comb
    begin
        for (int p = 0; p < PORTS; p++)
        begin
            data_nxt[p]    = data_r[p];
            inmode_nxt[p]  = inmode_r[p];
            outmode_nxt[p] = outmode_r[p];
        end
        for (int p = 0; p < 3; p++)
        begin
            cmp_val_nxt[p] = cmp_val_r[p];
            cmp_msk_nxt[p] = cmp_msk_r[p];
        end
        if (sfr_wr)
        begin
            if (sfr_addr == gpio_pkg::port0_data_addr)
                data_nxt[0] = bit_merge(data_r[0], sfr_wdata, sfr_bit_en, sfr_bit_sel);
            else if (sfr_addr == gpio_pkg::port1_data_addr)
                data_nxt[1] = bit_merge(data_r[1], sfr_wdata, sfr_bit_en, sfr_bit_sel);
            else if (sfr_addr == gpio_pkg::port2_data_addr)
                data_nxt[2] = bit_merge(data_r[2], sfr_wdata, sfr_bit_en, sfr_bit_sel);
            else if (sfr_addr == gpio_pkg::port3_data_addr)
                data_nxt[3] = bit_merge(data_r[3], sfr_wdata, sfr_bit_en, sfr_bit_sel);
            else if (sfr_addr == gpio_pkg::port4_data_addr && !sfr_bit_en)
                data_nxt[4] = sfr_wdata & gpio_pkg::port4_pin_mask;
            else if (sfr_addr == gpio_pkg::port0_input_mode_addr)
                inmode_nxt[0] = sfr_wdata;
            else if (sfr_addr == gpio_pkg::port1_input_mode_addr)
                inmode_nxt[1] = sfr_wdata;
            else if (sfr_addr == gpio_pkg::port2_input_mode_addr)
                inmode_nxt[2] = sfr_wdata;
            else if (sfr_addr == gpio_pkg::port3_input_mode_addr)
                inmode_nxt[3] = sfr_wdata;
            else if (sfr_addr == gpio_pkg::port0_output_mode_addr)
                outmode_nxt[0] = sfr_wdata;
            else if (sfr_addr == gpio_pkg::port1_output_mode_addr)
                outmode_nxt[1] = sfr_wdata;
            else if (sfr_addr == gpio_pkg::port2_output_mode_addr)
                outmode_nxt[2] = sfr_wdata;
            else if (sfr_addr == gpio_pkg::port3_output_mode_addr)
                outmode_nxt[3] = sfr_wdata;
            else if (sfr_addr == gpio_pkg::port4_output_mode_addr)
                outmode_nxt[4] = sfr_wdata & gpio_pkg::port4_pin_mask;
            else if (sfr_addr == gpio_pkg::port0_compare_value_addr)
                cmp_val_nxt[0] = sfr_wdata;
            else if (sfr_addr == gpio_pkg::port0_compare_mask_addr)
                cmp_msk_nxt[0] = sfr_wdata;
            else if (sfr_addr == gpio_pkg::port1_compare_value_addr)
                cmp_val_nxt[1] = sfr_wdata;
            else if (sfr_addr == gpio_pkg::port1_compare_mask_addr)
                cmp_msk_nxt[1] = sfr_wdata;
            else if (sfr_addr == gpio_pkg::port2_compare_value_addr)
                cmp_val_nxt[2] = sfr_wdata;
            else if (sfr_addr == gpio_pkg::port2_compare_mask_addr)
                cmp_msk_nxt[2] = sfr_wdata;
        end
    end

    // Enable kept apart from the ports: its own next-state and register
    always_comb
    begin
        int_en_nxt = int_en_r;
        if (sfr_wr && sfr_addr == gpio_pkg::int_enable_two_addr)
            int_en_nxt = sfr_wdata;
    end

    // Read data holds between reads, so a late bus sample still sees it
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (sfr_rd)
        begin
            // Latch read for read-modify-write, pins otherwise
            if (sfr_addr == gpio_pkg::port0_data_addr)
                rdata_nxt = sfr_rmw ? data_r[0] : pin_lvl[0];
            else if (sfr_addr == gpio_pkg::port1_data_addr)
                rdata_nxt = sfr_rmw ? data_r[1] : pin_lvl[1];
            else if (sfr_addr == gpio_pkg::port2_data_addr)
                rdata_nxt = sfr_rmw ? data_r[2] : pin_lvl[2];
            else if (sfr_addr == gpio_pkg::port3_data_addr)
                rdata_nxt = sfr_rmw ? data_r[3] : pin_lvl[3];
            else if (sfr_addr == gpio_pkg::port4_data_addr)
                rdata_nxt = (sfr_rmw ? data_r[4] : pin_lvl[4]) & gpio_pkg::port4_pin_mask;
            else if (sfr_addr == gpio_pkg::port0_input_mode_addr)
                rdata_nxt = inmode_r[0];
            else if (sfr_addr == gpio_pkg::port1_input_mode_addr)
                rdata_nxt = inmode_r[1];
            else if (sfr_addr == gpio_pkg::port2_input_mode_addr)
                rdata_nxt = inmode_r[2];
            else if (sfr_addr == gpio_pkg::port3_input_mode_addr)
                rdata_nxt = inmode_r[3];
            else if (sfr_addr == gpio_pkg::port0_output_mode_addr)
                rdata_nxt = outmode_r[0];
            else if (sfr_addr == gpio_pkg::port1_output_mode_addr)
                rdata_nxt = outmode_r[1];
            else if (sfr_addr == gpio_pkg::port2_output_mode_addr)
                rdata_nxt = outmode_r[2];
            else if (sfr_addr == gpio_pkg::port3_output_mode_addr)
                rdata_nxt = outmode_r[3];
            else if (sfr_addr == gpio_pkg::port4_output_mode_addr)
                rdata_nxt = outmode_r[4];
            else if (sfr_addr == gpio_pkg::port0_compare_value_addr)
                rdata_nxt = cmp_val_r[0];
            else if (sfr_addr == gpio_pkg::port0_compare_mask_addr)
                rdata_nxt = cmp_msk_r[0];
            else if (sfr_addr == gpio_pkg::port1_compare_value_addr)
                rdata_nxt = cmp_val_r[1];
            else if (sfr_addr == gpio_pkg::port1_compare_mask_addr)
                rdata_nxt = cmp_msk_r[1];
            else if (sfr_addr == gpio_pkg::port2_compare_value_addr)
                rdata_nxt = cmp_val_r[2];
            else if (sfr_addr == gpio_pkg::port2_compare_mask_addr)
                rdata_nxt = cmp_msk_r[2];
            else if (sfr_addr == gpio_pkg::int_enable_two_addr)
                rdata_nxt = int_en_r;
            else
                rdata_nxt = 8'h00;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int p = 0; p < PORTS; p++)
            begin
                data_r[p]    <= (p == 4) ? gpio_pkg::port4_data_reset : gpio_pkg::data_reset;
                inmode_r[p]  <= gpio_pkg::input_mode_reset;
                outmode_r[p] <= gpio_pkg::output_mode_reset;
            end
            for (int p = 0; p < 3; p++)
            begin
                cmp_val_r[p] <= gpio_pkg::compare_value_reset;
                cmp_msk_r[p] <= gpio_pkg::compare_mask_reset;
            end
        end
        else
        begin
            for (int p = 0; p < PORTS; p++)
            begin
                data_r[p]    <= data_nxt[p];
                inmode_r[p]  <= inmode_nxt[p];
                outmode_r[p] <= outmode_nxt[p];
            end
            for (int p = 0; p < 3; p++)
            begin
                cmp_val_r[p] <= cmp_val_nxt[p];
                cmp_msk_r[p] <= cmp_msk_nxt[p];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            int_en_r <= gpio_pkg::int_enable_reset;
        else
            int_en_r <= int_en_nxt;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rdata_r <= gpio_pkg::read_data_reset;
        else
            rdata_r <= rdata_nxt;
    end
endmodule : general_purpose_port_io

/* File: design/gpio_pkg.sv */
// Package of register addresses, reset values and field positions for the port block
package gpio_pkg;
    localparam logic [7:0] port0_data_addr         = 8'h80;
    localparam logic [7:0] port1_data_addr         = 8'h90;
    localparam logic [7:0] port2_data_addr         = 8'ha0;
    localparam logic [7:0] port3_data_addr         = 8'hb0;
    localparam logic [7:0] port4_data_addr         = 8'hc0;
    localparam logic [7:0] port0_input_mode_addr   = 8'hf1;
    localparam logic [7:0] port1_input_mode_addr   = 8'hf2;
    localparam logic [7:0] port2_input_mode_addr   = 8'hf3;
    localparam logic [7:0] port3_input_mode_addr   = 8'hf4;
    localparam logic [7:0] port0_output_mode_addr  = 8'ha4;
    localparam logic [7:0] port1_output_mode_addr  = 8'ha5;
    localparam logic [7:0] port2_output_mode_addr  = 8'ha6;
    localparam logic [7:0] port3_output_mode_addr  = 8'ha7;
    localparam logic [7:0] port4_output_mode_addr  = 8'hae;
    localparam logic [7:0] port0_compare_value_addr = 8'hd4;
    localparam logic [7:0] port0_compare_mask_addr  = 8'hd5;
    localparam logic [7:0] port1_compare_value_addr = 8'hd6;
    localparam logic [7:0] port1_compare_mask_addr  = 8'hd7;
    localparam logic [7:0] port2_compare_value_addr = 8'hd8;
    localparam logic [7:0] port2_compare_mask_addr  = 8'hd9;
    localparam logic [7:0] int_enable_two_addr      = 8'he7;
    localparam int         pattern_int_enable_bit   = 1;
    localparam logic [7:0] data_reset               = 8'hff;
    localparam logic [7:0] port4_data_reset         = 8'h7f;
    localparam logic [7:0] input_mode_reset         = 8'hff;
    localparam logic [7:0] output_mode_reset        = 8'h00;
    localparam logic [7:0] compare_value_reset      = 8'hff;
    localparam logic [7:0] compare_mask_reset       = 8'h00;
    localparam logic [7:0] int_enable_reset         = 8'h00;
    localparam logic [7:0] read_data_reset          = 8'h00;
    localparam logic [7:0] port4_pin_mask           = 8'h7f;
endpackage : gpio_pkg

/* File: design/pin_sync.sv */
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            stage1_r <= '0;
            stage2_r <= '0;
        end
        else
        begin
            stage1_r <= async_in;
            stage2_r <= stage1_r;
        end
    end

    assign sync_out = stage2_r;
endmodule : pin_sync
